/* logic/lb_nibble_fifo.v */
`default_nettype none

module lb_nibble_fifo (
  // Clock and reset.
  input wire ref_clk_i,
  input wire nrst_i,
  // Write side.
  input wire wr_en_i,
  input wire [3:0] wr_data_i,
  // Read side.
  input wire rd_en_i,
  output reg [3:0] rd_data_o,
  // Fill state.
  output reg [3:0] count_o,
  output wire full_o,
  output wire empty_o
);
  `include "phy_ctrl_defines.vh"

  reg [3:0] mem [0:7];
  reg [2:0] wptr;
  reg [2:0] rptr;
  wire do_wr;
  wire do_rd;

  // Writes into a full buffer and reads from an empty one are dropped.
  assign full_o = (count_o == `LBD_N8);
  assign empty_o = (count_o == 4'h0);
  assign do_wr = wr_en_i & ~full_o;
  assign do_rd = rd_en_i & ~empty_o;

  // Storage array; no reset is needed on the data words.
  always @(posedge ref_clk_i) begin
    if (do_wr) begin
      mem[wptr] <= wr_data_i;
    end
  end

  // Pointers, fill count and registered read data.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wptr <= 3'h0;
      rptr <= 3'h0;
      count_o <= 4'h0;
      rd_data_o <= 4'h0;
    end else begin
      if (do_wr) begin
        wptr <= wptr + 3'h1;
      end
      if (do_rd) begin
        rptr <= rptr + 3'h1;
        rd_data_o <= mem[rptr];
      end
      if (do_wr && !do_rd) begin
        count_o <= count_o + 4'h1;
      end else if (do_rd && !do_wr) begin
        count_o <= count_o - 4'h1;
      end
    end
  end
endmodule // lb_nibble_fifo

`default_nettype wire

/* logic/phy_ctrl_defines.vh */
`ifndef PHY_CTRL_DEFINES_VH
`define PHY_CTRL_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_SUMMARY 6'h10
`define IDX_SPECIAL 6'h11
`define IDX_STATUS1 6'h12

// Reset values.
`define RST_SPECIAL 16'h0108
`define RST_STATUS1 16'h0000

// Special control register fields.
`define B_CLK_OFF 15
`define B_PS_EN 14
`define F_PS_HI 13
`define F_PS_LO 12
`define B_SCR_BYP 11
`define F_LBD_HI 9
`define F_LBD_LO 8
`define B_COL_FD 4
`define B_IRQ_POL 3
`define B_IRQ_TEST 2
`define B_IRQ_EN 1
`define B_IRQ_OE 0
`define SPECIAL_WMASK 16'hfb1f

// Interrupt status register fields.
`define NUM_EVT 3
`define ST_FLAG_LO 13
`define ST_EN_LO 5
`define ST_EN_MASK 16'h00e0

// Summary register fields.
`define SUM_PEND 7
`define SUM_DUPLEX 2
`define SUM_LINK 0

// Power save mode encodings.
`define PS_NORMAL 2'h0
`define PS_RSVD 2'h1
`define PS_SLEEP 2'h2

// Loopback depth field encodings and depths in nibbles.
`define LBD_SEL4 2'h0
`define LBD_SEL5 2'h1
`define LBD_SEL6 2'h2
`define LBD_N4 4'h4
`define LBD_N5 4'h5
`define LBD_N6 4'h6
`define LBD_N8 4'h8

// Loopback buffer geometry.
`define LB_AW 3
`define LB_DW 4
`define LB_WORDS 8

// Link pulse period in active sleep.
`define NLP_PERIOD_MS 1400
`define CLK_FREQ_KHZ 125000

`endif

/* logic/phy_ctrl_irq_status_regs.v */
// Function
// [R1] Bit 15 stops internal clocks; accepted only while in standard power-down.
// [R2] Bit 14 enables power save; clear keeps normal operation.
// [R3] Field 13-12: 0 normal, 2 active sleep, 1 reserved.
// [R4] Active sleep powers down all but management and energy detect; pulse each 1.4 s.
// [R5] Active sleep leaves automatically when a link partner is detected.
// [R6] Bit 11 bypasses the 100 Mb/s scrambler.
// [R7] Far-end loopback uses an elastic nibble buffer between the two clocks.
// [R8] Field 9-8 gives 4, 5, 6 or 8 nibbles; reset value 1.
// [R9] Software picks the depth from packet length and clock tolerance.
// [R10] Bit 4 also allows collision signalling in full duplex.
// [R11] Bit 3 sets interrupt polarity; reset 1 means idle high.
// [R12] Bit 2 forces an interrupt for as long as it is set.
// [R13] Bit 1 gates event interrupts through their individual enables.
// [R14] Bit 0 turns the shared pin from power-down input into interrupt output.
// [R15] Status bit 15 latches link quality change while linked; cleared on read.
// [R16] Status bit 14 latches energy detect change; cleared on read.
// [R17] Status bit 13 latches link status change; cleared on read.
// [R18] Status bits 7, 6, 5 are read-write enables for those events.
// [R19] Summary bit 7 flags a pending interrupt; status read clears it.
// [R20] Pin asserts when output enabled and test or enabled pending event.
`default_nettype none

// The parameter default below needs the named constants before the header.
`include "phy_ctrl_defines.vh"

module phy_ctrl_irq_status_regs #(
  parameter NLP_CYCLES = `NLP_PERIOD_MS * `CLK_FREQ_KHZ
) (
  // Clock and reset.
  input wire ref_clk_i,
  input wire nrst_i,
  // Wishbone slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Line and link status from the PHY core.
  input wire link_up_i,
  input wire link_quality_i,
  input wire energy_detect_i,
  input wire full_duplex_i,
  input wire ieee_powerdown_i,
  input wire col_raw_i,
  // Power, clock and datapath controls.
  output reg clk_shutdown_o,
  output reg active_sleep_o,
  output reg nlp_pulse_o,
  output reg scrambler_bypass_o,
  output reg col_o,
  // Far-end loopback nibble stream.
  input wire lb_in_valid_i,
  input wire [3:0] lb_in_data_i,
  input wire lb_tx_req_i,
  output reg lb_out_valid_o,
  output wire [3:0] lb_out_data_o,
  output reg lb_overflow_o,
  output reg lb_underflow_o,
  // Shared interrupt or power-down pin.
  input wire irq_or_powerdown_pin_i,
  output reg irq_or_powerdown_pin_o,
  output reg irq_or_powerdown_pin_oe_o,
  output reg powerdown_req_o
);
  localparam ST_NORMAL = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_AWAKE = 2'h2;
  localparam [31:0] NLP_FULL = NLP_CYCLES - 1;
  localparam [27:0] NLP_LAST = NLP_FULL[27:0];
  localparam [15:0] STATUS_RST = `RST_STATUS1;

  // True when the word index of the bus address equals idx.
  function hit;
    input [7:0] adr;
    input [5:0] idx;
    begin
      hit = (adr[7:2] == idx);
    end
  endfunction

  // Loopback depth field to fill threshold in nibbles.
  function [3:0] lb_depth;
    input [1:0] sel;
    begin
      case (sel)
        `LBD_SEL4: lb_depth = `LBD_N4;
        `LBD_SEL5: lb_depth = `LBD_N5;
        `LBD_SEL6: lb_depth = `LBD_N6;
        default: lb_depth = `LBD_N8;
      endcase
    end
  endfunction

  reg [15:0] special;
  reg [`NUM_EVT-1:0] evt_flag;
  reg [`NUM_EVT-1:0] evt_en;
  reg sum_pend;
  reg link_d;
  reg quality_d;
  reg energy_d;
  reg [1:0] ps_state;
  reg [1:0] next_ps_state;
  reg [27:0] nlp_cnt;
  reg lb_run;
  reg [15:0] next_special;
  reg [31:0] next_dat;

  wire bus_req;
  wire bus_commit;
  wire wr_commit;
  wire status_read;
  wire [`NUM_EVT-1:0] evt_pulse;
  wire [`NUM_EVT-1:0] evt_new;
  wire [15:0] status_word;
  wire [15:0] wmask;
  wire [15:0] merged;
  wire sleep_sel;
  wire event_pend;
  wire irq_active;
  wire lb_rd;
  wire [3:0] lb_count;
  wire lb_full;
  wire lb_empty;

  // Ack is raised one cycle after the request; the transfer commits at the edge that ends the ack cycle.
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_commit = bus_req & wb_ack_o;
  assign wr_commit = bus_commit & wb_we_i;
  assign status_read = bus_commit & ~wb_we_i & hit(wb_adr_i, `IDX_STATUS1);

  // Bus handshake.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  // Byte lanes 0 and 1 carry the 16-bit registers.
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign merged = (wb_dat_i[15:0] & wmask) | (special & ~wmask);

  // Next control value; reserved bits stay zero.
  always @* begin
    next_special = merged & `SPECIAL_WMASK;
    if (!ieee_powerdown_i) begin
      next_special[`B_CLK_OFF] = 1'b0; // [R1]
    end
  end

  // Control register write.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      special <= `RST_SPECIAL; // [R8] [R11]
    end else if (wr_commit && hit(wb_adr_i, `IDX_SPECIAL)) begin
      special <= next_special;
    end
  end

  // Event enables live in the low byte of the status register.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      evt_en <= STATUS_RST[`ST_EN_LO+`NUM_EVT-1:`ST_EN_LO];
    end else if (wr_commit && hit(wb_adr_i, `IDX_STATUS1) && wb_sel_i[0]) begin
      evt_en <= wb_dat_i[`ST_EN_LO+`NUM_EVT-1:`ST_EN_LO]; // [R18]
    end
  end

  // Previous line states for change detection.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      link_d <= 1'b0;
      quality_d <= 1'b0;
      energy_d <= 1'b0;
    end else begin
      link_d <= link_up_i;
      quality_d <= link_quality_i;
      energy_d <= energy_detect_i;
    end
  end

  // Event order matches status bits 13, 14, 15.
  assign evt_pulse[0] = link_up_i ^ link_d; // [R17]
  assign evt_pulse[1] = energy_detect_i ^ energy_d; // [R16]
  assign evt_pulse[2] = (link_quality_i ^ quality_d) & link_up_i; // [R15]

  // Sticky flags: a read clears them, a new event in the same cycle wins.
  genvar g;
  generate
    for (g = 0; g < `NUM_EVT; g = g + 1) begin : g_evt
      always @(posedge ref_clk_i) begin
        if (!nrst_i) begin
          evt_flag[g] <= 1'b0;
        end else if (evt_pulse[g]) begin
          evt_flag[g] <= 1'b1; // [R15] [R16] [R17]
        end else if (status_read) begin
          evt_flag[g] <= 1'b0; // [R15] [R16] [R17]
        end
      end
    end
  endgenerate

  // A newly latched, enabled event marks the summary flag.
  assign evt_new = evt_pulse & evt_en & {`NUM_EVT{special[`B_IRQ_EN]}};

  // Summary pending flag, cleared by a status read unless set again.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      sum_pend <= 1'b0;
    end else if (|evt_new) begin
      sum_pend <= 1'b1; // [R19]
    end else if (status_read) begin
      sum_pend <= 1'b0; // [R19]
    end
  end

  // Status word as software sees it.
  assign status_word = {evt_flag[2], evt_flag[1], evt_flag[0], 5'h00,
                        evt_en[2], evt_en[1], evt_en[0], 5'h00};

  // Read data mux; unmapped addresses read as zero and still ack.
  always @* begin
    next_dat = 32'h00000000;
    if (hit(wb_adr_i, `IDX_SPECIAL)) begin
      next_dat[15:0] = special;
    end else if (hit(wb_adr_i, `IDX_STATUS1)) begin
      next_dat[15:0] = status_word;
    end else if (hit(wb_adr_i, `IDX_SUMMARY)) begin
      next_dat[`SUM_PEND] = sum_pend; // [R19]
      next_dat[`SUM_DUPLEX] = full_duplex_i;
      next_dat[`SUM_LINK] = link_up_i;
    end
  end

  // Read data is captured as ack rises and held during the ack cycle.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req && !wb_ack_o) begin
      wb_dat_o <= next_dat;
    end
  end

  // Only enable plus the sleep code selects sleep; the reserved code acts as normal.
  assign sleep_sel = special[`B_PS_EN] &
                     (special[`F_PS_HI:`F_PS_LO] == `PS_SLEEP); // [R2] [R3]

  // Power save state: sleep until energy appears, then stay up.
  always @* begin
    case (ps_state)
      ST_NORMAL: begin
        next_ps_state = sleep_sel ? ST_SLEEP : ST_NORMAL; // [R2]
      end
      ST_SLEEP: begin
        if (!sleep_sel) begin
          next_ps_state = ST_NORMAL;
        end else if (energy_detect_i) begin
          next_ps_state = ST_AWAKE; // [R5]
        end else begin
          next_ps_state = ST_SLEEP;
        end
      end
      ST_AWAKE: begin
        next_ps_state = sleep_sel ? ST_AWAKE : ST_NORMAL;
      end
      default: begin
        next_ps_state = ST_NORMAL;
      end
    endcase
  end

  // State register and the link pulse timer used while asleep.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ps_state <= ST_NORMAL;
      nlp_cnt <= 28'h0000000;
      nlp_pulse_o <= 1'b0;
      active_sleep_o <= 1'b0;
    end else begin
      ps_state <= next_ps_state;
      active_sleep_o <= (next_ps_state == ST_SLEEP); // [R4]
      nlp_pulse_o <= 1'b0;
      if (ps_state != ST_SLEEP) begin
        nlp_cnt <= 28'h0000000;
      end else if (nlp_cnt == NLP_LAST) begin
        nlp_cnt <= 28'h0000000;
        nlp_pulse_o <= 1'b1; // [R4]
      end else begin
        nlp_cnt <= nlp_cnt + 28'h0000001;
      end
    end
  end

  // Datapath controls and collision gating.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      clk_shutdown_o <= 1'b0;
      scrambler_bypass_o <= 1'b0;
      col_o <= 1'b0;
    end else begin
      clk_shutdown_o <= special[`B_CLK_OFF] & ieee_powerdown_i; // [R1]
      scrambler_bypass_o <= special[`B_SCR_BYP]; // [R6]
      col_o <= col_raw_i & (~full_duplex_i | special[`B_COL_FD]); // [R10]
    end
  end

  // Elastic loopback buffer absorbing the receive and transmit rate gap.
  lb_nibble_fifo u_lb_fifo (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .wr_en_i(lb_in_valid_i),
    .wr_data_i(lb_in_data_i),
    .rd_en_i(lb_rd),
    .rd_data_o(lb_out_data_o),
    .count_o(lb_count),
    .full_o(lb_full),
    .empty_o(lb_empty)
  ); // [R7]

  assign lb_rd = lb_run & lb_tx_req_i & ~lb_empty;

  // Draining starts once the chosen depth has filled and stops when empty.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      lb_run <= 1'b0;
      lb_out_valid_o <= 1'b0;
      lb_overflow_o <= 1'b0;
      lb_underflow_o <= 1'b0;
    end else begin
      if (!lb_run && lb_count >= lb_depth(special[`F_LBD_HI:`F_LBD_LO])) begin
        lb_run <= 1'b1; // [R8]
      end else if (lb_run && lb_empty) begin
        lb_run <= 1'b0; // [R7]
      end
      lb_out_valid_o <= lb_rd;
      lb_overflow_o <= lb_in_valid_i & lb_full;
      lb_underflow_o <= lb_run & lb_tx_req_i & lb_empty;
    end
  end

  // Interrupt request from test bit or enabled pending events.
  assign event_pend = |(evt_flag & evt_en); // [R13]
  assign irq_active = special[`B_IRQ_TEST] |
                      (special[`B_IRQ_EN] & event_pend); // [R12] [R13] [R20]

  // Shared pin: interrupt output or power-down input, pin low requests power-down.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      irq_or_powerdown_pin_o <= 1'b1;
      irq_or_powerdown_pin_oe_o <= 1'b0;
      powerdown_req_o <= 1'b0;
    end else begin
      irq_or_powerdown_pin_oe_o <= special[`B_IRQ_OE]; // [R14]
      irq_or_powerdown_pin_o <= irq_active ^ special[`B_IRQ_POL]; // [R11] [R20]
      powerdown_req_o <= ~special[`B_IRQ_OE] & ~irq_or_powerdown_pin_i; // [R14]
    end
  end
endmodule // phy_ctrl_irq_status_regs

`default_nettype wire

/* testbench/phy_ctrl_irq_status_regs_chk.sv */
`default_nettype none
module phy_ctrl_irq_status_regs_chk #(
  parameter NLP_CYCLES = 20
) (
  // Clock and reset.
  input wire ref_clk_i,
  input wire nrst_i,
  // Register bus.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  // Line status and controls.
  input wire energy_detect_i,
  input wire full_duplex_i,
  input wire ieee_powerdown_i,
  input wire col_raw_i,
  input wire clk_shutdown_o,
  input wire active_sleep_o,
  input wire nlp_pulse_o,
  input wire scrambler_bypass_o,
  input wire col_o,
  // Shared pin.
  input wire irq_or_powerdown_pin_i,
  input wire irq_or_powerdown_pin_oe_o,
  input wire powerdown_req_o
);
  reg [1:0] up;
  wire live;

  // Checks start two edges after reset so registered outputs have settled.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) up <= 2'h0;
    else up <= {up[0], 1'b1};
  end
  assign live = nrst_i & up[1];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!live);

  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer longer than one cycle");
  AST_SCR_FOLLOW: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h44 && wb_sel_i[1]
    |-> ##2 scrambler_bypass_o == $past(wb_dat_i[11], 2)) else $error("bypass not following write");
  AST_CLK_OFF: assert property (clk_shutdown_o |-> $past(ieee_powerdown_i))
    else $error("clock shutdown outside power-down");
  AST_COL_HALF: assert property ((!full_duplex_i || !col_raw_i) |=> col_o == $past(col_raw_i))
    else $error("collision output wrong");
  AST_PD_REQ: assert property ((!irq_or_powerdown_pin_oe_o && !irq_or_powerdown_pin_i) [*3]
    |-> powerdown_req_o) else $error("power-down input ignored");
  AST_PD_OFF: assert property (irq_or_powerdown_pin_oe_o [*2] |-> !powerdown_req_o)
    else $error("power-down request while pin drives");
  AST_NLP_ASLEEP: assert property (nlp_pulse_o |-> $past(active_sleep_o))
    else $error("link pulse while awake");
  AST_NLP_GAP: assert property (nlp_pulse_o |=> !nlp_pulse_o [*8])
    else $error("link pulses too close");
  AST_WAKE: assert property (active_sleep_o && energy_detect_i |-> ##[1:3] !active_sleep_o)
    else $error("no wake on energy");
endmodule // phy_ctrl_irq_status_regs_chk

bind phy_ctrl_irq_status_regs phy_ctrl_irq_status_regs_chk #(.NLP_CYCLES(NLP_CYCLES)) u_chk (.*);
`default_nettype wire

/* testbench/phy_ctrl_irq_status_regs_tb.sv */
`default_nettype none
module phy_ctrl_irq_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Design inputs.
  logic ref_clk_i = 0, nrst_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0, lb_in_data_i = 0;
  logic [31:0] wb_dat_i = 0;
  logic link_up_i = 0, link_quality_i = 0, energy_detect_i = 0, full_duplex_i = 0;
  logic ieee_powerdown_i = 0, col_raw_i = 0, lb_in_valid_i = 0, lb_tx_req_i = 0;
  logic irq_or_powerdown_pin_i = 1;
  // Design outputs.
  logic [31:0] wb_dat_o;
  logic [3:0] lb_out_data_o;
  logic wb_ack_o, clk_shutdown_o, active_sleep_o, nlp_pulse_o, scrambler_bypass_o, col_o;
  logic lb_out_valid_o, lb_overflow_o, lb_underflow_o, irq_or_powerdown_pin_o;
  logic irq_or_powerdown_pin_oe_o, powerdown_req_o;
  int fails = 0, samples_checked = 0, seed = 38;
  logic [15:0] rd, d;
  logic [31:0] r;
  logic [15:0] sl [3] = '{16'h2108, 16'h4108, 16'h6108};

  // Free-running 125 MHz clock.
  always #4 ref_clk_i = ~ref_clk_i;

  phy_ctrl_irq_status_regs #(.NLP_CYCLES(20)) dut (.*);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // One classic bus cycle; read data lands in rd.
  task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] v);
    int n;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0, v};
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    wb(a, 1'b0, 16'h0);
    chk(rd, e);
  endtask

  task automatic push(input logic [3:0] v);
    @(posedge ref_clk_i);
    lb_in_valid_i <= 1;
    lb_in_data_i <= v;
  endtask

  // Expected control readback: writable bits only, clock-off only in power-down.
  function automatic logic [15:0] ctl_exp(input logic [15:0] v, input logic pd);
    ctl_exp = v & 16'hfb1f;
    if (!pd) ctl_exp[15] = 1'b0;
  endfunction

  task results;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    results();
  end

  // Main sequence.
  initial begin
    int n, dep, got;
    tick(16);
    nrst_i <= 1;
    rchk(8'h44, 16'h0108);
    rchk(8'h48, 16'h0000);
    rchk(8'h80, 16'h0000);
    chk(irq_or_powerdown_pin_oe_o, 0);
    // Random control writes with random line state.
    repeat (8) begin
      d = $random(seed);
      d[12] = 1'b0;
      r = $random(seed);
      d[15] = d[15] & r[0];
      ieee_powerdown_i <= r[0];
      full_duplex_i <= r[1];
      col_raw_i <= r[2];
      wb(8'h44, 1'b1, d);
      tick(2);
      rchk(8'h44, ctl_exp(d, r[0]));
      chk(scrambler_bypass_o, d[11]);
      chk(clk_shutdown_o, d[15] & r[0]);
      chk(col_o, r[2] & (~r[1] | d[4]));
    end
    ieee_powerdown_i <= 0;
    // Active sleep, link pulses, wake and re-arm.
    wb(8'h44, 1'b1, 16'h6108);
    tick(3);
    chk(active_sleep_o, 1);
    n = 0;
    repeat (45) begin
      @(posedge ref_clk_i);
      if (nlp_pulse_o === 1'b1) n++;
    end
    chk(n inside {2, 3}, 1);
    energy_detect_i <= 1;
    tick(4);
    chk(active_sleep_o, 0);
    energy_detect_i <= 0;
    tick(4);
    chk(active_sleep_o, 0);
    for (int k = 0; k < 3; k++) begin
      wb(8'h44, 1'b1, sl[k]);
      tick(3);
      chk(active_sleep_o, k == 2);
    end
    // Event flags, enables, summary flag and pin.
    wb(8'h48, 1'b0, 16'h0);
    wb(8'h48, 1'b1, 16'h00e0);
    wb(8'h44, 1'b1, 16'h000b);
    tick(2);
    chk(irq_or_powerdown_pin_o, 1);
    chk(irq_or_powerdown_pin_oe_o, 1);
    for (int k = 0; k < 3; k++) begin
      case (k)
        0: link_up_i <= 1;
        1: energy_detect_i <= 1;
        default: link_quality_i <= 1;
      endcase
      tick(3);
      chk(irq_or_powerdown_pin_o, 0);
      rchk(8'h40, {8'h00, 1'b1, 4'h0, full_duplex_i, 2'b01});
      rchk(8'h48, 16'h00e0 | (16'h2000 << k));
      rchk(8'h48, 16'h00e0);
      rchk(8'h40, {13'h0, full_duplex_i, 2'b01});
      tick(2);
      chk(irq_or_powerdown_pin_o, 1);
    end
    wb(8'h48, 1'b1, 16'h00c0);
    link_up_i <= 0;
    tick(3);
    chk(irq_or_powerdown_pin_o, 1);
    rchk(8'h48, 16'h20c0);
    wb(8'h44, 1'b1, 16'h0009);
    wb(8'h48, 1'b1, 16'h00e0);
    link_up_i <= 1;
    tick(3);
    chk(irq_or_powerdown_pin_o, 1);
    rchk(8'h48, 16'h20e0);
    for (int k = 0; k < 2; k++) begin
      wb(8'h44, 1'b1, k ? 16'h000d : 16'h0005);
      tick(2);
      chk(irq_or_powerdown_pin_o, k == 0);
      tick(10);
      chk(irq_or_powerdown_pin_o, k == 0);
    end
    // Shared pin as power-down input.
    wb(8'h44, 1'b1, 16'h0108);
    irq_or_powerdown_pin_i <= 0;
    tick(4);
    chk(powerdown_req_o, 1);
    chk(irq_or_powerdown_pin_oe_o, 0);
    irq_or_powerdown_pin_i <= 1;
    tick(3);
    chk(powerdown_req_o, 0);
    // Loopback depth: no output one nibble short, full drain at depth.
    for (int s = 0; s < 4; s++) begin
      dep = (s == 3) ? 8 : 4 + s;
      wb(8'h44, 1'b1, {6'h0, s[1:0], 8'h08});
      for (int i = 0; i < dep - 1; i++) push(i[3:0] ^ 4'h5);
      @(posedge ref_clk_i);
      lb_in_valid_i <= 0;
      lb_tx_req_i <= 1;
      @(posedge ref_clk_i);
      lb_tx_req_i <= 0;
      repeat (2) begin
        @(posedge ref_clk_i);
        chk(lb_out_valid_o, 0);
      end
      push(dep[3:0] - 4'h1 ^ 4'h5);
      @(posedge ref_clk_i);
      lb_in_valid_i <= 0;
      tick(2);
      got = 0;
      lb_tx_req_i <= 1;
      for (int j = 0; j < dep + 2; j++) begin
        @(posedge ref_clk_i);
        if (j == dep - 1) lb_tx_req_i <= 0;
        chk(lb_overflow_o | lb_underflow_o, 1'b0);
        if (lb_out_valid_o === 1'b1) begin
          chk(lb_out_data_o, got[3:0] ^ 4'h5);
          got++;
        end
      end
      chk(got, dep);
    end
    // Corner cases: a nibble past full overflows, a request past empty underflows.
    for (int i = 0; i < 9; i++) push(i[3:0]);
    @(posedge ref_clk_i);
    lb_in_valid_i <= 0;
    @(posedge ref_clk_i);
    chk(lb_overflow_o, 1);
    lb_tx_req_i <= 1;
    tick(9);
    lb_tx_req_i <= 0;
    @(posedge ref_clk_i);
    chk(lb_underflow_o, 1);
    tick(5);
    results();
  end
endmodule // phy_ctrl_irq_status_regs_tb
`default_nettype wire
